//--- hw/cft_params.svh
`ifndef CFT_PARAMS_SVH
`define CFT_PARAMS_SVH

// Acquisition clock
`define CFT_CLK_HZ 32'h0BEB_C200

// Bit rates in bits per second
`define CFT_RATE_MIN 20'h0_1388
`define CFT_RATE_MAX 20'hF_4240
`define CFT_RATE_P1 20'h0_2710
`define CFT_RATE_P2 20'h0_4E20
`define CFT_RATE_P3 20'h0_C350
`define CFT_RATE_P4 20'h1_86A0
`define CFT_RATE_P5 20'h1_E848
`define CFT_RATE_P6 20'h3_D090
`define CFT_RATE_P7 20'h7_A120
`define CFT_RATE_P8 20'hC_3500
`define CFT_SEL_CUSTOM 4'hA
`define CFT_RST_SEL 4'h7

// Don't-care encodings
`define CFT_ID_STD_DC 30'h0000_0800
`define CFT_ID_EXT_DC 30'h2000_0000
`define CFT_BYTE_DC 9'h100

// Frame field lengths in bits, minus one where used as a last index
`define CFT_BASE_LAST 5'h0A
`define CFT_EXT_LAST 5'h11
`define CFT_STD_CTRL_LAST 5'h04
`define CFT_EXT_CTRL_LAST 5'h05
`define CFT_BYTE_LAST 5'h07
`define CFT_STUFF_RUN 3'h5
`define CFT_IDLE_BITS 4'hB

// Register byte offsets
`define CFT_OFF_CONDITION 8'h00
`define CFT_OFF_ID_WIDTH 8'h04
`define CFT_OFF_ID_VALUE 8'h08
`define CFT_OFF_FIRST_BYTE 8'h0C
`define CFT_OFF_SECOND_BYTE 8'h10
`define CFT_OFF_RATE_SEL 8'h14
`define CFT_OFF_RATE_CUSTOM 8'h18
`define CFT_OFF_STATUS 8'h1C
`define CFT_OFF_CLEAR 8'h20
`define CFT_OFF_ENABLE 8'h24

// Event bits: trigger fired, error frame, start of frame
`define CFT_EV_W 3
`define CFT_RESP_OKAY 2'h0
`define CFT_RESP_SLVERR 2'h2

`endif

//--- hw/cft_pkg.sv
package cft_pkg;

  typedef enum logic [2:0] {
    start_of_frame = 3'h0,
    remote_frame = 3'h1,
    identifier_match = 3'h2,
    identifier_plus_byte_match = 3'h3,
    error_frame = 3'h4
  } cft_cond_type;

  typedef enum logic {
    standard_identifier_width = 1'b0,
    extended_identifier_width = 1'b1
  } cft_width_type;

  typedef struct packed {
    cft_cond_type cond;
    cft_width_type width;
    logic [29:0] id;
    logic [8:0] byte1;
    logic [8:0] byte2;
  } cft_cfg_type;

  typedef enum logic [8:0] {
    S_HUNT = 9'h001,
    S_WAIT = 9'h002,
    S_BASE = 9'h004,
    S_RTR1 = 9'h008,
    S_IDE = 9'h010,
    S_EXT = 9'h020,
    S_RTR2 = 9'h040,
    S_CTRL = 9'h080,
    S_DATA = 9'h100
  } cft_state_type;

endpackage

//--- hw/cft_bit_timer.sv
`timescale 1ns/1ps
module cft_bit_timer #(
  parameter int PER_W = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Synchronised bus level and bit period in clocks
  input wire logic rx_i,
  input wire logic [PER_W-1:0] period_i,
  // Sample strobe and sampled level
  output logic sample_o,
  output logic bit_o
);
  logic prev_reg;
  logic [PER_W-1:0] cnt_reg;

  // Hard resync on every recessive-to-dominant edge
  wire fall = prev_reg & ~rx_i;
  wire wrap = cnt_reg >= (period_i - PER_W'(1));
  wire [PER_W-1:0] mid = period_i >> 1;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
      cnt_reg <= '0;
      sample_o <= 1'b0;
      bit_o <= 1'b1;
    end else begin
      prev_reg <= rx_i;
      cnt_reg <= (fall | wrap) ? '0 : cnt_reg + PER_W'(1);
      sample_o <= (cnt_reg == mid) & ~fall;
      bit_o <= rx_i;
    end
  end
endmodule // cft_bit_timer

//--- hw/cft_destuff.sv
`timescale 1ns/1ps
`include "cft_params.svh"
module cft_destuff (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Sampled bits
  input wire logic sample_i,
  input wire logic bit_i,
  input wire logic active_i,
  input wire logic sof_i,
  // Destuffed bits and bus state
  output logic valid_o,
  output logic bit_o,
  output logic err_o,
  output logic idle_o
);
  logic [2:0] run_reg;
  logic last_reg;
  logic [3:0] rec_reg;

  wire same = bit_i == last_reg;
  wire stuff = run_reg == `CFT_STUFF_RUN;
  wire rec_full = rec_reg == `CFT_IDLE_BITS;

  assign idle_o = rec_full;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      run_reg <= 3'h0;
      last_reg <= 1'b1;
      rec_reg <= 4'h0;
      valid_o <= 1'b0;
      bit_o <= 1'b1;
      err_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      err_o <= 1'b0;
      if (sample_i) begin
        rec_reg <= bit_i ? (rec_full ? rec_reg : rec_reg + 4'h1) : 4'h0;
        bit_o <= bit_i;
        last_reg <= bit_i;
        if (sof_i) begin
          run_reg <= 3'h1;
        end else if (active_i && stuff) begin
          // Sixth equal bit breaks stuffing: error frame
          err_o <= same;
          run_reg <= 3'h1;
        end else if (active_i) begin
          valid_o <= 1'b1;
          run_reg <= same ? run_reg + 3'h1 : 3'h1;
        end
      end
    end
  end
endmodule // cft_destuff

//--- hw/cft_trigger_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cft_params.svh"
// Behaviour
// - five trigger conditions selectable by software and readable back
// - identifier match fires only on equal identifier at programmed width
// - identifier-plus-data fires only when identifier and data byte match
// - identifier value ranges zero to two to the width, 11 or 29
// - with 11-bit width, value 2048 ignores the identifier
// - with 29-bit width, value 536870912 ignores the identifier
// - identifier width selects standard or extended, readable back
// - first data byte value 0 to 256, used in identifier-plus-data
// - first data byte value 256 ignores the first byte
// - second data byte value 0 to 256 compared, 256 ignores it
// - bit rate from presets or custom 5000 to 1000000 bits/s
module cft_trigger_top
  import cft_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PER_W = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Observed bus pin
  input wire logic can_rx_i,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Trigger and interrupt
  output logic trigger_o,
  output logic irq_o
);
  localparam int EW = `CFT_EV_W;

  // Pin synchroniser
  logic rx_meta_reg;
  logic rx_sync_reg;

  // Registers
  cft_cfg_type cfg_reg;
  logic [3:0] rate_sel_reg;
  logic [19:0] custom_reg;
  logic [PER_W-1:0] period_reg;
  logic [EW-1:0] status_reg;
  logic [EW-1:0] enable_reg;

  // Bus slave state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic trigger_reg;
  logic irq_reg;

  // Frame parser state
  cft_state_type state_reg;
  logic [4:0] cnt_reg;
  logic [28:0] id_sh_reg;
  logic rtr_reg;
  logic ide_reg;
  logic [3:0] dlc_reg;
  logic [7:0] byte_sh_reg;
  logic byte_idx_reg;
  logic [7:0] byte1_reg;
  logic id_hit_reg;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Identifier compare at the programmed width, with don't care
  function automatic logic id_ok(input cft_cfg_type c,
                                 input logic [28:0] got,
                                 input logic ide);
    logic r;
    r = 1'b0;
    if (c.width == standard_identifier_width) begin
      r = ~ide & ((c.id == `CFT_ID_STD_DC)
           | (c.id[10:0] == got[10:0]));
    end else begin
      r = ide & ((c.id == `CFT_ID_EXT_DC)
           | (c.id[28:0] == got));
    end
    return r;
  endfunction

  // Data byte compare, the top bit is the don't-care value
  function automatic logic byte_ok(input logic [8:0] want,
                                   input logic [7:0] got);
    return want[8] | (want[7:0] == got);
  endfunction

  function automatic logic [19:0] preset_rate(input logic [3:0] sel);
    logic [19:0] r;
    case (sel)
      4'h0: r = `CFT_RATE_MIN;
      4'h1: r = `CFT_RATE_P1;
      4'h2: r = `CFT_RATE_P2;
      4'h3: r = `CFT_RATE_P3;
      4'h4: r = `CFT_RATE_P4;
      4'h5: r = `CFT_RATE_P5;
      4'h6: r = `CFT_RATE_P6;
      4'h7: r = `CFT_RATE_P7;
      4'h8: r = `CFT_RATE_P8;
      4'h9: r = `CFT_RATE_MAX;
      default: r = custom_reg;
    endcase
    return r;
  endfunction

  // Read decode: hit flag above the data word
  function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    logic [32:0] r;
    o = 8'(a);
    r = {1'b0, 32'h0000_0000};
    if (o == `CFT_OFF_CONDITION) begin
      r = {1'b1, 29'h0, cfg_reg.cond};
    end else if (o == `CFT_OFF_ID_WIDTH) begin
      r = {1'b1, 31'h0, cfg_reg.width};
    end else if (o == `CFT_OFF_ID_VALUE) begin
      r = {1'b1, 2'h0, cfg_reg.id};
    end else if (o == `CFT_OFF_FIRST_BYTE) begin
      r = {1'b1, 23'h0, cfg_reg.byte1};
    end else if (o == `CFT_OFF_SECOND_BYTE) begin
      r = {1'b1, 23'h0, cfg_reg.byte2};
    end else if (o == `CFT_OFF_RATE_SEL) begin
      r = {1'b1, 28'h0, rate_sel_reg};
    end else if (o == `CFT_OFF_RATE_CUSTOM) begin
      r = {1'b1, 12'h0, custom_reg};
    end else if (o == `CFT_OFF_STATUS) begin
      r = {1'b1, 29'h0, status_reg};
    end else if (o == `CFT_OFF_CLEAR) begin
      r = {1'b1, 32'h0000_0000};
    end else if (o == `CFT_OFF_ENABLE) begin
      r = {1'b1, 29'h0, enable_reg};
    end
    return r;
  endfunction

  // Write decode with range checks; out-of-range values are refused
  wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire [7:0] wa = 8'(aw_addr_reg);
  wire [32:0] wr_old = reg_read(aw_addr_reg);
  wire [31:0] wv = merge(wr_old[31:0], w_data_reg, w_strb_reg);
  wire [29:0] id_lim = (cfg_reg.width == extended_identifier_width) ?
                       `CFT_ID_EXT_DC : `CFT_ID_STD_DC;
  wire wr_cond = wr_go && wa == `CFT_OFF_CONDITION &&
                 wv <= 32'(error_frame);
  wire wr_width = wr_go && wa == `CFT_OFF_ID_WIDTH && wv[31:1] == '0;
  wire wr_id = wr_go && wa == `CFT_OFF_ID_VALUE &&
               wv <= 32'(id_lim);
  wire wr_b1 = wr_go && wa == `CFT_OFF_FIRST_BYTE &&
               wv <= 32'(`CFT_BYTE_DC);
  wire wr_b2 = wr_go && wa == `CFT_OFF_SECOND_BYTE &&
               wv <= 32'(`CFT_BYTE_DC);
  wire wr_sel = wr_go && wa == `CFT_OFF_RATE_SEL &&
                wv <= 32'(`CFT_SEL_CUSTOM);
  wire wr_cust = wr_go && wa == `CFT_OFF_RATE_CUSTOM &&
                 wv >= 32'(`CFT_RATE_MIN) &&
                 wv <= 32'(`CFT_RATE_MAX);
  wire wr_clr = wr_go && wa == `CFT_OFF_CLEAR;
  wire wr_en = wr_go && wa == `CFT_OFF_ENABLE;
  wire wr_ok = wr_cond | wr_width | wr_id | wr_b1 | wr_b2 | wr_sel |
               wr_cust | wr_clr | wr_en;
  wire [32:0] rd_val = reg_read(s_axi_araddr_i);
  wire ar_take = s_axi_arvalid_i & arready_reg;

  // Bit rate to bit period in clocks
  wire [19:0] eff_rate = preset_rate(rate_sel_reg);
  wire [31:0] per_full = `CFT_CLK_HZ / 32'(eff_rate);

  // Bit recovery
  wire sample;
  wire rx_bit;
  wire bv;
  wire bbit;
  wire stuff_err;
  wire bus_idle;
  wire in_frame = ~(state_reg == S_HUNT || state_reg == S_WAIT);

  cft_bit_timer #(.PER_W(PER_W)) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .rx_i(rx_sync_reg),
    .period_i(period_reg),
    .sample_o(sample),
    .bit_o(rx_bit)
  );

  wire sof = state_reg == S_WAIT && sample && !rx_bit;

  cft_destuff u_destuff (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sample_i(sample),
    .bit_i(rx_bit),
    .active_i(in_frame),
    .sof_i(sof),
    .valid_o(bv),
    .bit_o(bbit),
    .err_o(stuff_err),
    .idle_o(bus_idle)
  );

  // Decision points
  wire [28:0] id_next = {id_sh_reg[27:0], bbit};
  wire [7:0] byte_now = {byte_sh_reg[6:0], bbit};
  wire std_done = state_reg == S_IDE && bv && !bbit;
  wire ext_done = state_reg == S_EXT && bv && cnt_reg == `CFT_EXT_LAST;
  wire std_hit = id_ok(cfg_reg, id_sh_reg, 1'b0);
  wire ext_hit = id_ok(cfg_reg, id_next, 1'b1);
  wire byte_done = state_reg == S_DATA && bv && cnt_reg == `CFT_BYTE_LAST;
  wire need2 = ~cfg_reg.byte2[8];
  wire [4:0] ctrl_last = ide_reg ? `CFT_EXT_CTRL_LAST : `CFT_STD_CTRL_LAST;
  wire [3:0] dlc_next = {dlc_reg[2:0], bbit};
  wire ctrl_done = state_reg == S_CTRL && bv && cnt_reg == ctrl_last;
  wire more_bytes = need2 && dlc_reg > 4'h1;

  wire f_start = cfg_reg.cond == start_of_frame && sof;
  wire f_remote = cfg_reg.cond == remote_frame &&
                  ((std_done && rtr_reg) ||
                   (state_reg == S_RTR2 && bv && bbit));
  wire f_id = cfg_reg.cond == identifier_match &&
              ((std_done && std_hit) ||
               (ext_done && ext_hit));
  wire f_data = cfg_reg.cond == identifier_plus_byte_match && byte_done &&
                id_hit_reg &&
                ((!byte_idx_reg && !more_bytes && !need2 &&
                  byte_ok(cfg_reg.byte1, byte_now)) ||
                 (byte_idx_reg && byte_ok(cfg_reg.byte1, byte1_reg) &&
                  byte_ok(cfg_reg.byte2, byte_now)));
  wire f_err = cfg_reg.cond == error_frame && stuff_err;
  wire fire = f_start | f_remote | f_id | f_data | f_err;
  wire [EW-1:0] events = {sof, stuff_err, fire};
  wire [EW-1:0] clr = wr_clr ? wv[EW-1:0] : '0;
  wire [EW-1:0] status_next = (status_reg & ~clr) | events;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= can_rx_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_reg <= '{start_of_frame, standard_identifier_width,
                   `CFT_ID_STD_DC, `CFT_BYTE_DC, `CFT_BYTE_DC};
      rate_sel_reg <= `CFT_RST_SEL;
      custom_reg <= `CFT_RATE_P7;
      period_reg <= '0;
      status_reg <= '0;
      enable_reg <= '0;
      trigger_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_cond) cfg_reg.cond <= cft_cond_type'(wv[2:0]);
      if (wr_width) cfg_reg.width <= cft_width_type'(wv[0]);
      if (wr_id) cfg_reg.id <= wv[29:0];
      if (wr_b1) cfg_reg.byte1 <= wv[8:0];
      if (wr_b2) cfg_reg.byte2 <= wv[8:0];
      if (wr_sel) rate_sel_reg <= wv[3:0];
      if (wr_cust) custom_reg <= wv[19:0];
      if (wr_en) enable_reg <= wv[EW-1:0];
      period_reg <= PER_W'(per_full);
      status_reg <= status_next;
      trigger_reg <= fire;
      irq_reg <= |(status_next & enable_reg);
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CFT_RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr_i;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `CFT_RESP_OKAY : `CFT_RESP_SLVERR;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `CFT_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val[31:0];
      rresp_reg <= rd_val[32] ? `CFT_RESP_OKAY : `CFT_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Frame parser: header and up to the first two data bytes, then wait for idle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= S_HUNT;
      cnt_reg <= 5'h00;
      id_sh_reg <= '0;
      rtr_reg <= 1'b0;
      ide_reg <= 1'b0;
      dlc_reg <= 4'h0;
      byte_sh_reg <= 8'h00;
      byte_idx_reg <= 1'b0;
      byte1_reg <= 8'h00;
      id_hit_reg <= 1'b0;
    end else if (stuff_err) begin
      state_reg <= S_HUNT;
    end else begin
      case (state_reg)
        S_HUNT: begin
          if (bus_idle) state_reg <= S_WAIT;
        end
        S_WAIT: begin
          cnt_reg <= 5'h00;
          byte_idx_reg <= 1'b0;
          id_hit_reg <= 1'b0;
          if (sof) state_reg <= S_BASE;
        end
        S_BASE: begin
          if (bv) begin
            id_sh_reg <= id_next;
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `CFT_BASE_LAST) state_reg <= S_RTR1;
          end
        end
        S_RTR1: begin
          if (bv) begin
            rtr_reg <= bbit;
            state_reg <= S_IDE;
          end
        end
        S_IDE: begin
          if (bv) begin
            ide_reg <= bbit;
            cnt_reg <= 5'h00;
            id_hit_reg <= std_done && std_hit;
            state_reg <= bbit ? S_EXT : S_CTRL;
          end
        end
        S_EXT: begin
          if (bv) begin
            id_sh_reg <= id_next;
            cnt_reg <= cnt_reg + 5'h01;
            if (ext_done) begin
              id_hit_reg <= ext_hit;
              state_reg <= S_RTR2;
            end
          end
        end
        S_RTR2: begin
          if (bv) begin
            rtr_reg <= bbit;
            cnt_reg <= 5'h00;
            state_reg <= S_CTRL;
          end
        end
        S_CTRL: begin
          if (bv) begin
            dlc_reg <= dlc_next;
            cnt_reg <= ctrl_done ? 5'h00 : cnt_reg + 5'h01;
            if (ctrl_done) begin
              state_reg <= (rtr_reg || dlc_next == 4'h0) ? S_HUNT : S_DATA;
            end
          end
        end
        S_DATA: begin
          if (bv) begin
            byte_sh_reg <= byte_now;
            cnt_reg <= byte_done ? 5'h00 : cnt_reg + 5'h01;
            if (byte_done) begin
              byte1_reg <= byte_now;
              byte_idx_reg <= 1'b1;
              if (byte_idx_reg || !more_bytes) state_reg <= S_HUNT;
            end
          end
        end
        default: state_reg <= S_HUNT;
      endcase
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign trigger_o = trigger_reg;
  assign irq_o = irq_reg;
endmodule // cft_trigger_top

//--- tb/cft_trigger_props.sv
`timescale 1ns/1ps
`include "cft_params.svh"
module cft_trigger_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // AXI4-Lite handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Trigger
  input wire logic trigger_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_TRIG_GAP: assert property ($rose(trigger_o) |=> !trigger_o [*8])
    else $error("trigger gap");
  AST_RESET_IDLE: assert property ($fell(rst_i) |-> s_axi_awready_o
    && s_axi_arready_o && !s_axi_bvalid_o && !s_axi_rvalid_o && !trigger_o)
    else $error("reset idle");
  AST_AW_TAKEN: assert property (s_axi_awvalid_i && s_axi_awready_o
    |=> !s_axi_awready_o) else $error("awready held");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b hold");
  AST_B_DROP: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o) else $error("b drop");
  AST_B_RESP: assert property (s_axi_bvalid_o |-> s_axi_bresp_o ==
    `CFT_RESP_OKAY || s_axi_bresp_o == `CFT_RESP_SLVERR) else $error("bresp");
  AST_R_LATENCY: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("r latency");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r hold");
  AST_R_DROP: assert property (s_axi_rvalid_o && s_axi_rready_i
    |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("r drop");
  AST_AR_LOW: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("arready low");
  cover property (trigger_o);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == `CFT_RESP_SLVERR);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // cft_trigger_props

bind cft_trigger_top cft_trigger_props props_u (.*);

//--- tb/cft_can_node.sv
`timescale 1ns/1ps
module cft_can_node #(
  parameter int BIT_CLKS = 200
) (
  // Clock
  input wire logic clock_i,
  // Bus level, 1 is recessive
  output logic rx_o
);
  logic last;
  int run;
  initial rx_o = 1'b1;
  task automatic put(input logic b);
    rx_o <= b;
    repeat (BIT_CLKS) @(posedge clock_i);
  endtask
  // Stuff bit after five equal bits
  task automatic sbit(input logic b);
    put(b);
    run = (b == last) ? run + 1 : 1;
    last = b;
    if (run == 5) begin
      put(~b);
      last = ~b;
      run = 1;
    end
  endtask
  task automatic frame(input logic [28:0] id, input logic ext, rtr,
      input logic [3:0] dlc, input logic [15:0] d);
    logic [28:0] v;
    v = ext ? id : {id[10:0], 18'h0_0000};
    repeat (11) put(1'b1);
    last = 1'b1;
    run = 0;
    sbit(1'b0);
    for (int i = 28; i >= 18; i--) sbit(v[i]);
    if (ext) begin
      sbit(1'b1);
      sbit(1'b1);
      for (int i = 17; i >= 0; i--) sbit(v[i]);
    end
    sbit(rtr);
    sbit(1'b0);
    sbit(1'b0);
    for (int i = 3; i >= 0; i--) sbit(dlc[i]);
    for (int i = 0; i < 16; i++) if (!rtr && i < 8 * dlc) sbit(d[15 - i]);
    put(1'b1);
  endtask
  // Stuff error after start bit
  task automatic stuff_err();
    repeat (11) put(1'b1);
    repeat (7) put(1'b0);
    put(1'b1);
  endtask
endmodule // cft_can_node

//--- tb/cft_trigger_top_tb.sv
`timescale 1ns/1ps
`include "cft_params.svh"
module cft_trigger_top_tb;
  import cft_pkg::*;
  localparam logic [1:0] OK = `CFT_RESP_OKAY;
  localparam logic [1:0] ER = `CFT_RESP_SLVERR;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, tc, trig_cnt = 32'h0;
  logic awr, wrd, bv, arr, rv, trig, irq, can_rx, ext;
  logic [1:0] br, rr;
  int bad_count = 0, n_checks = 0;
  cft_trigger_top dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .can_rx_i(can_rx),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .trigger_o(trig),
    .irq_o(irq)
  );
  cft_can_node node_u (.clock_i(clock_i), .rx_o(can_rx));
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge clock_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 200);
    chk($sformatf("bresp %h", a), 32'(br), 32'(er));
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int n;
    @(posedge clock_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 200);
    chk($sformatf("rdata %h", a), rdat, e);
    chk($sformatf("rresp %h", a), 32'(rr), 32'(er));
    rre <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] c, input logic w,
      input logic [29:0] id, input logic [8:0] b1, b2);
    ext = w;
    wr(`CFT_OFF_CONDITION, {29'h0, c}, OK);
    rd(`CFT_OFF_CONDITION, {29'h0, c}, OK);
    wr(`CFT_OFF_ID_WIDTH, {31'h0, w}, OK);
    rd(`CFT_OFF_ID_WIDTH, {31'h0, w}, OK);
    wr(`CFT_OFF_ID_VALUE, {2'h0, id}, OK);
    wr(`CFT_OFF_FIRST_BYTE, {23'h0, b1}, OK);
    wr(`CFT_OFF_SECOND_BYTE, {23'h0, b2}, OK);
    wr(`CFT_OFF_CLEAR, 32'h0000_0007, OK);
  endtask
  task automatic frm(input logic [28:0] id, input logic rtr,
      input logic [3:0] dlc, input logic [15:0] d, input logic e);
    tc = trig_cnt;
    node_u.frame(id, ext, rtr, dlc, d);
    chk("trigger count", trig_cnt - tc, {31'h0, e});
  endtask
  initial begin
    #550000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`CFT_OFF_CONDITION, 32'h0, OK);
    rd(`CFT_OFF_ID_WIDTH, 32'h0, OK);
    rd(`CFT_OFF_ID_VALUE, 32'h800, OK);
    rd(`CFT_OFF_FIRST_BYTE, 32'h100, OK);
    rd(`CFT_OFF_SECOND_BYTE, 32'h100, OK);
    rd(`CFT_OFF_RATE_SEL, 32'h7, OK);
    rd(`CFT_OFF_RATE_CUSTOM, 32'h7_A120, OK);
    rd(`CFT_OFF_STATUS, 32'h0, OK);
    rd(`CFT_OFF_ENABLE, 32'h0, OK);
    rd(8'h28, 32'h0, ER);
    wr(`CFT_OFF_STATUS, 32'h1, ER);
    wr(`CFT_OFF_CONDITION, 32'h5, ER);
    wr(`CFT_OFF_ID_VALUE, 32'h801, ER);
    wr(`CFT_OFF_FIRST_BYTE, 32'h101, ER);
    wr(`CFT_OFF_RATE_CUSTOM, 32'h1387, ER);
    wr(`CFT_OFF_RATE_CUSTOM, 32'hF_4241, ER);
    wr(`CFT_OFF_RATE_CUSTOM, 32'hF_4240, OK);
    rd(`CFT_OFF_RATE_CUSTOM, 32'hF_4240, OK);
    wr(`CFT_OFF_RATE_SEL, 32'h9, OK);
    wr(`CFT_OFF_ENABLE, 32'h7, OK);
    cfg(start_of_frame, 1'h0, 30'h800, 9'h100, 9'h100);
    frm(29'h123, 1'h0, 4'h0, 16'h0, 1'h1);
    rd(`CFT_OFF_STATUS, 32'h5, OK);
    chk("irq", 32'(irq), 32'h1);
    wr(`CFT_OFF_CLEAR, 32'h7, OK);
    rd(`CFT_OFF_STATUS, 32'h0, OK);
    chk("irq", 32'(irq), 32'h0);
    cfg(remote_frame, 1'h0, 30'h800, 9'h100, 9'h100);
    frm(29'h123, 1'h1, 4'h0, 16'h0, 1'h1);
    cfg(identifier_match, 1'h0, 30'h123, 9'h100, 9'h100);
    frm(29'h123, 1'h0, 4'h0, 16'h0, 1'h1);
    frm(29'h124, 1'h0, 4'h0, 16'h0, 1'h0);
    cfg(identifier_match, 1'h0, 30'h800, 9'h100, 9'h100);
    frm(29'h555, 1'h0, 4'h0, 16'h0, 1'h1);
    cfg(identifier_match, 1'h1, 30'h0ABC_DEF1, 9'h100, 9'h100);
    frm(29'h0ABC_DEF1, 1'h0, 4'h0, 16'h0, 1'h1);
    cfg(identifier_match, 1'h1, 30'h2000_0000, 9'h100, 9'h100);
    frm(29'h1555_5555, 1'h0, 4'h0, 16'h0, 1'h1);
    cfg(identifier_plus_byte_match, 1'h0, 30'h123, 9'h05A, 9'h100);
    frm(29'h123, 1'h0, 4'h1, 16'h5A00, 1'h1);
    frm(29'h123, 1'h0, 4'h1, 16'h5B00, 1'h0);
    cfg(identifier_plus_byte_match, 1'h0, 30'h123, 9'h100, 9'h100);
    frm(29'h123, 1'h0, 4'h1, 16'h5B00, 1'h1);
    cfg(identifier_plus_byte_match, 1'h0, 30'h123, 9'h05A, 9'h03C);
    frm(29'h123, 1'h0, 4'h2, 16'h5A3C, 1'h1);
    frm(29'h123, 1'h0, 4'h2, 16'h5A3D, 1'h0);
    cfg(error_frame, 1'h0, 30'h800, 9'h100, 9'h100);
    tc = trig_cnt;
    node_u.stuff_err();
    chk("error trigger", trig_cnt - tc, 32'h1);
    rd(`CFT_OFF_STATUS, 32'h7, OK);
    chk("irq", 32'(irq), 32'h1);
    wr(`CFT_OFF_ENABLE, 32'h0, OK);
    @(posedge clock_i);
    chk("irq masked", 32'(irq), 32'h0);
    close_out();
  end
endmodule // cft_trigger_top_tb
